//--- design/pfc_cfg.svh
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
// Register byte offsets on APB
`define PFC_OFF_CTRL 12'h000
`define PFC_OFF_ADDR 12'h004
`define PFC_OFF_WDATA 12'h008
`define PFC_OFF_STATUS 12'h00C
`define PFC_OFF_RDATA 12'h010
`define PFC_OFF_PINS 12'h014
// Control field positions
`define PFC_CTRL_GO 0
`define PFC_CTRL_OP_LSB 1
`define PFC_CTRL_OP_MSB 4
`define PFC_CTRL_IDHV 5
// Command codes written on the flash bus
`define PFC_UNLOCK_ADDR1 19'h05555
`define PFC_UNLOCK_ADDR2 19'h02AAA
`define PFC_UNLOCK_DATA1 8'hAA
`define PFC_UNLOCK_DATA2 8'h55
`define PFC_CMD_RESET 8'hF0
`define PFC_CMD_AUTOSEL 8'h90
`define PFC_CMD_PROGRAM 8'hA0
`define PFC_CMD_ERASE_SETUP 8'h80
`define PFC_CMD_CHIP_ERASE 8'h10
`define PFC_CMD_SECTOR_ERASE 8'h30
`define PFC_CMD_SUSPEND 8'hB0
`define PFC_CMD_RESUME 8'h30
// Identification offsets
`define PFC_ID_MFR_ADDR 19'h00000
`define PFC_ID_DEV_ADDR 19'h00001
`define PFC_ID_PROT_ADDR 19'h00002
// Bus cycle phase length in clocks (10 ns each)
`define PFC_PHASE_NS 60
`define PFC_CLK_NS 10
`define PFC_PHASE_CYC (((`PFC_PHASE_NS)+(`PFC_CLK_NS)-1)/(`PFC_CLK_NS))
`endif

//--- design/pfc_pkg.sv
package pfc_pkg;
    // Operations software may order through the control register
    typedef enum logic [3:0] {
        PFC_OP_READ, PFC_OP_RESET1, PFC_OP_RESET3, PFC_OP_AUTOSEL,
        PFC_OP_PROGRAM, PFC_OP_CHIP_ERASE, PFC_OP_SECTOR_ERASE,
        PFC_OP_SUSPEND, PFC_OP_RESUME, PFC_OP_RAW_WRITE
    } pfc_op_e;
    // Flash bus cycle engine states
    typedef enum logic [2:0] {
        PFC_CY_IDLE, PFC_CY_SETUP, PFC_CY_STROBE, PFC_CY_HOLD, PFC_CY_DONE
    } pfc_cy_e;
endpackage

//--- design/pfc_cycle.sv
`timescale 1ns/1ps
`include "pfc_cfg.svh"
// One flash bus cycle: a write strobe or an output-enabled read
module pfc_cycle #(
    parameter int PHASE = `PFC_PHASE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic is_write,
    input wire logic [18:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] data_in,
    output logic done,
    output logic [7:0] rdata,
    output logic [18:0] addr_pin,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic chip_en_n,
    output logic out_en_n,
    output logic wr_en_n
);
    typedef struct packed {
        pfc_pkg::pfc_cy_e st;
        logic [7:0] cnt;
        logic wr;
        logic done;
        logic [7:0] rdata;
        logic [18:0] addr;
        logic [7:0] dout;
        logic oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } pfc_cyc_s;
    pfc_cyc_s s_q, s_d;
    logic [7:0] din_a_q, din_b_q, din_c_q;

    // Three-stage capture of data pins; value used once stages two and three agree
    always_ff @(posedge clock) begin
        din_a_q <= data_in;
        din_b_q <= din_a_q;
        din_c_q <= din_b_q;
    end

    // Address set before either strobe falls, data held past the rising edge
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            pfc_pkg::PFC_CY_IDLE: begin
                if (start) begin
                    s_d.st = pfc_pkg::PFC_CY_SETUP;
                    s_d.wr = is_write;
                    s_d.addr = addr;
                    s_d.dout = wdata;
                    s_d.oe = is_write; // Drive only on writes, never into a read
                    s_d.cnt = 8'(PHASE);
                end
            end
            pfc_pkg::PFC_CY_SETUP: begin
                s_d.ce_n = 1'b0;
                s_d.cnt = s_q.cnt - 8'h01;
                if (s_q.cnt == 8'h00) begin
                    s_d.st = pfc_pkg::PFC_CY_STROBE;
                    s_d.cnt = 8'(PHASE);
                    s_d.we_n = ~s_q.wr;
                    s_d.oe_n = s_q.wr;
                end
            end
            pfc_pkg::PFC_CY_STROBE: begin
                // Waits at zero for settled data rather than wrapping round
                if (s_q.cnt != 8'h00)
                    s_d.cnt = s_q.cnt - 8'h01;
                if (s_q.cnt == 8'h00 && din_b_q == din_c_q) begin
                    s_d.st = pfc_pkg::PFC_CY_HOLD;
                    s_d.rdata = din_c_q;
                    s_d.we_n = 1'b1;
                    s_d.oe_n = 1'b1;
                    s_d.cnt = 8'(PHASE);
                end
            end
            pfc_pkg::PFC_CY_HOLD: begin
                s_d.cnt = s_q.cnt - 8'h01;
                if (s_q.cnt == 8'h00) begin
                    s_d.ce_n = 1'b1;
                    s_d.oe = 1'b0;
                    s_d.st = pfc_pkg::PFC_CY_DONE;
                end
            end
            pfc_pkg::PFC_CY_DONE: begin
                s_d.done = 1'b1;
                s_d.st = pfc_pkg::PFC_CY_IDLE;
            end
            default: s_d.st = pfc_pkg::PFC_CY_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
            s_q.ce_n <= 1'b1;
            s_q.oe_n <= 1'b1;
            s_q.we_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign rdata = s_q.rdata;
    assign addr_pin = s_q.addr;
    assign data_out = s_q.dout;
    assign data_oe = s_q.oe;
    assign chip_en_n = s_q.ce_n;
    assign out_en_n = s_q.oe_n;
    assign wr_en_n = s_q.we_n;
endmodule

//--- design/pfc_host.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "pfc_cfg.svh"
// Overview of operation
// - High voltage on id pin selects identification, reading A0, A1, A6
// - Host writes with write enable low, chip enable low, output high
// - Reset is F0 anywhere, or AA, 55, F0 unlock form
// - Unlock then 90 enters identification at offsets zero and one
// - Program is unlock, A0, then data to the target address
// - Erase is unlock, 80, unlock, then 10 chip or 30 sector
// - Chip and output enable low, write high, reads array data
module pfc_host (
    input wire logic clock,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [18:0] flash_addr,
    input wire logic [7:0] flash_data_in,
    output logic [7:0] flash_data_out,
    output logic flash_data_oe,
    output logic chip_enable_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic identifier_high_voltage
);
    typedef struct packed {
        logic busy;
        logic err;
        logic [3:0] op;
        logic [2:0] step;
        logic [2:0] nsteps;
        logic [18:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic idhv;
        logic wr_ok;
        logic start;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pfc_host_s;
    pfc_host_s s_q, s_d;
    logic cyc_done;
    logic [7:0] cyc_rdata;
    logic [18:0] cyc_addr_w, pin_addr;
    logic [7:0] cyc_wdata_w, pin_dout;
    logic cyc_is_wr, pin_oe, pin_ce_n, pin_oe_n, pin_we_n;
    logic [26:0] cyc_word;

    // Number of bus cycles each ordered operation needs
    function automatic logic [2:0] op_len(input logic [3:0] op);
        case (op)
            4'(pfc_pkg::PFC_OP_RESET3): op_len = 3'h3;
            4'(pfc_pkg::PFC_OP_AUTOSEL): op_len = 3'h3;
            4'(pfc_pkg::PFC_OP_PROGRAM): op_len = 3'h4;
            4'(pfc_pkg::PFC_OP_CHIP_ERASE): op_len = 3'h6;
            4'(pfc_pkg::PFC_OP_SECTOR_ERASE): op_len = 3'h6;
            default: op_len = 3'h1;
        endcase
    endfunction

    // Address and data of step n; unlock pairs come first in every multi-cycle sequence
    function automatic logic [26:0] step_word(input logic [3:0] op,
            input logic [2:0] n, input logic [18:0] a, input logic [7:0] d);
        logic [26:0] w;
        w = {a, d};
        if (op_len(op) != 3'h1) begin
            if (n == 3'h0 || n == 3'h3)
                w = {`PFC_UNLOCK_ADDR1, `PFC_UNLOCK_DATA1};
            else if (n == 3'h1 || n == 3'h4)
                w = {`PFC_UNLOCK_ADDR2, `PFC_UNLOCK_DATA2};
        end
        if (n == 3'h2) begin
            case (op)
                4'(pfc_pkg::PFC_OP_RESET3):
                    w = {`PFC_UNLOCK_ADDR1, `PFC_CMD_RESET};
                4'(pfc_pkg::PFC_OP_AUTOSEL):
                    w = {`PFC_UNLOCK_ADDR1, `PFC_CMD_AUTOSEL};
                4'(pfc_pkg::PFC_OP_PROGRAM):
                    w = {`PFC_UNLOCK_ADDR1, `PFC_CMD_PROGRAM};
                default: w = {`PFC_UNLOCK_ADDR1, `PFC_CMD_ERASE_SETUP};
            endcase
        end
        if (n == 3'h3 && op == 4'(pfc_pkg::PFC_OP_PROGRAM))
            w = {a, d};
        if (n == 3'h5) begin
            if (op == 4'(pfc_pkg::PFC_OP_CHIP_ERASE))
                w = {`PFC_UNLOCK_ADDR1, `PFC_CMD_CHIP_ERASE};
            else
                w = {a, `PFC_CMD_SECTOR_ERASE};
        end
        if (n == 3'h0) begin
            case (op)
                4'(pfc_pkg::PFC_OP_RESET1): w = {a, `PFC_CMD_RESET};
                4'(pfc_pkg::PFC_OP_SUSPEND): w = {a, `PFC_CMD_SUSPEND};
                4'(pfc_pkg::PFC_OP_RESUME): w = {a, `PFC_CMD_RESUME};
                default: ;
            endcase
        end
        step_word = w;
    endfunction

    // APB slave and sequencer; every access answers in its first access cycle
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel && !penable) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h00000000;
            case (paddr)
                `PFC_OFF_CTRL:
                    s_d.prdata = {26'h0, s_q.idhv, s_q.op, 1'b0};
                `PFC_OFF_ADDR: s_d.prdata = {13'h0, s_q.addr};
                `PFC_OFF_WDATA: s_d.prdata = {24'h0, s_q.wdata};
                `PFC_OFF_STATUS: s_d.prdata = {30'h0, s_q.err, s_q.busy};
                `PFC_OFF_RDATA: s_d.prdata = {24'h0, s_q.rdata};
                `PFC_OFF_PINS:
                    s_d.prdata = {22'h0, pin_ce_n, pin_oe_n, s_q.rdata};
                default: s_d.pslverr = 1'b1;
            endcase
            // Decided at setup so the answer and the effect agree
            s_d.wr_ok = pwrite && !s_q.busy;
            if (pwrite && s_q.busy)
                s_d.pslverr = 1'b1; // Refused while a sequence runs
        end
        // A write lands only at the edge that completes the access
        if (psel && penable && s_q.pready && s_q.wr_ok) begin
            case (paddr)
                `PFC_OFF_CTRL: begin
                    s_d.idhv = pwdata[`PFC_CTRL_IDHV];
                    if (pwdata[`PFC_CTRL_GO]) begin
                        s_d.op = pwdata[`PFC_CTRL_OP_MSB:`PFC_CTRL_OP_LSB];
                        s_d.nsteps = op_len(s_d.op);
                        s_d.step = 3'h0;
                        s_d.busy = 1'b1;
                        s_d.err = 1'b0;
                        s_d.start = 1'b1;
                    end
                end
                `PFC_OFF_ADDR: s_d.addr = pwdata[18:0];
                `PFC_OFF_WDATA: s_d.wdata = pwdata[7:0];
                `PFC_OFF_STATUS: ;
                `PFC_OFF_RDATA: ;
                `PFC_OFF_PINS: ;
                default: ;
            endcase
        end
        // Advance through the command steps as each bus cycle ends
        if (s_q.busy && cyc_done) begin
            if (s_q.op == 4'(pfc_pkg::PFC_OP_READ))
                s_d.rdata = cyc_rdata;
            if (s_q.step + 3'h1 >= s_q.nsteps) begin
                s_d.busy = 1'b0;
            end else begin
                s_d.step = s_q.step + 3'h1;
                s_d.start = 1'b1;
            end
        end
    end

    assign cyc_is_wr = s_q.op != 4'(pfc_pkg::PFC_OP_READ);
    assign cyc_word = step_word(s_q.op, s_q.step, s_q.addr, s_q.wdata);
    assign cyc_addr_w = cyc_word[26:8];
    assign cyc_wdata_w = cyc_word[7:0];

    pfc_cycle u_cycle (
        .clock(clock),
        .rst(rst),
        .start(s_q.start),
        .is_write(cyc_is_wr),
        .addr(cyc_addr_w),
        .wdata(cyc_wdata_w),
        .data_in(flash_data_in),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .addr_pin(pin_addr),
        .data_out(pin_dout),
        .data_oe(pin_oe),
        .chip_en_n(pin_ce_n),
        .out_en_n(pin_oe_n),
        .wr_en_n(pin_we_n)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign flash_addr = pin_addr;
    assign flash_data_out = pin_dout;
    assign flash_data_oe = pin_oe;
    assign chip_enable_n = pin_ce_n;
    assign output_enable_n = pin_oe_n;
    assign write_enable_n = pin_we_n;
    assign identifier_high_voltage = s_q.idhv;
endmodule

//--- bench/pfc_host_monitor.sv
`timescale 1ns/1ps
// Port checks of the flash host: APB answer and flash strobe order
module pfc_host_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [18:0] flash_addr,
    input wire logic [7:0] flash_data_out,
    input wire logic flash_data_oe,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // One-cycle answer right after every setup cycle
    property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
    a_answer: assert property (p_answer) else $error("apb answer late");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_unmap;
        psel && !penable && paddr > 12'h014 |=> pslverr && !prdata;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    // Strobes: write needs chip select and no output enable
    property p_wr; !write_enable_n |-> !chip_enable_n && output_enable_n;
    endproperty
    a_wr: assert property (p_wr) else $error("bad write strobe");
    property p_float; flash_data_oe |-> output_enable_n; endproperty
    a_float: assert property (p_float) else $error("bus fight");
    // Address and data stay put while the device may latch them
    property p_addr;
        !chip_enable_n && $past(!chip_enable_n) |-> $stable(flash_addr);
    endproperty
    a_addr: assert property (p_addr) else $error("addr moved");
    property p_data;
        !write_enable_n && $past(!write_enable_n) |-> $stable(flash_data_out);
    endproperty
    a_data: assert property (p_data) else $error("data moved");
    property p_fall; $fell(write_enable_n) |-> $past(!chip_enable_n, 6);
    endproperty
    a_fall: assert property (p_fall) else $error("we before ce");
    property p_rise;
        $rose(chip_enable_n) |-> $past(write_enable_n && output_enable_n, 6);
    endproperty
    a_rise: assert property (p_rise) else $error("ce rose early");
endmodule

bind pfc_host pfc_host_monitor i_mon (.clock, .rst, .paddr, .psel,
    .penable, .prdata, .pready, .pslverr, .flash_addr, .flash_data_out,
    .flash_data_oe, .chip_enable_n, .output_enable_n, .write_enable_n);

//--- bench/pfc_flash_model.sv
`timescale 1ns/1ps
// Behavioural byte-wide flash with the unlock command decoder
module pfc_flash_model #(
    parameter logic [7:0] MFR_ID = 8'h3B, // Arbitrary, odd parity
    parameter logic [7:0] DEV_ID = 8'hC2, // Arbitrary, odd parity
    parameter logic [7:0] PROT = 8'h00,
    parameter int PROG_T = 300,
    parameter int ERASE_T = 1500
) (
    input wire logic [18:0] addr,
    input wire logic [7:0] din,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic hv,
    output logic [7:0] dout
);
    logic [7:0] mem [bit [18:0]];
    logic [18:0] a_l;
    logic [7:0] pd = 8'h00;
    bit idm, susp, serase, tog;
    int st, cnt;
    wire wr_n = ce_n | we_n;
    wire drv = !ce_n && !oe_n && we_n;
    initial dout = 8'h00;
    function automatic logic [7:0] rd(logic [18:0] a);
        if (cnt > 0 && !susp) return {~pd[7], tog, 6'h00};
        if (hv || idm) return a[1] ? {7'h00, PROT[a[18:16]]} :
            (a[0] ? DEV_ID : MFR_ID);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction
    // Released pins show the inverse of the last byte, never a hold
    always @(negedge drv) begin
        dout = ~dout;
        tog = ~tog;
    end
    always @(*) if (drv) dout = rd(addr);
    // Address on the later falling strobe, data on the earlier rising
    always @(negedge wr_n) a_l = addr;
    always @(posedge wr_n) if (!$isunknown(din)) cmd(a_l, din);
    // Embedded timer runs with the chip deselected, frozen in suspend
    always #10 begin
        if (cnt > 0 && !susp) cnt--;
        if (cnt == 0) serase = 0;
    end
    task automatic erase(logic [18:0] a, bit one);
        foreach (mem[k])
            if (!PROT[k[18:16]] && (!one || k[18:16] == a[18:16]))
                mem[k] = 8'hFF;
        pd = 8'hFF;
        cnt = ERASE_T;
        serase = one;
    endtask
    task automatic cmd(logic [18:0] a, logic [7:0] d);
        bit u1, u2, c;
        u1 = a[14:0] == 15'h5555 && d == 8'hAA;
        u2 = a[14:0] == 15'h2AAA && d == 8'h55;
        c = a[14:0] == 15'h5555;
        if (cnt > 0) begin
            if (serase && d == 8'hB0) susp = 1;
            if (susp && d == 8'h30) susp = 0;
        end else if (st == 6) begin
            if (!PROT[a[18:16]]) begin
                mem[a] = (mem.exists(a) ? mem[a] : 8'hFF) & d;
                pd = d;
                cnt = PROG_T;
            end
            st = 0;
        end else if (d == 8'hF0) begin
            st = 0;
            idm = 0;
        end else case (st)
            0, 3: st = u1 ? st + 1 : 0;
            1, 4: st = u2 ? st + 1 : 0;
            2: begin
                st = (c && d == 8'hA0) ? 6 : (c && d == 8'h80) ? 3 : 0;
                if (c && d == 8'h90) idm = 1;
            end
            default: begin
                st = 0;
                if (c && d == 8'h10) erase(a, 0);
                if (d == 8'h30) erase(a, 1);
            end
        endcase
    endtask
endmodule

//--- bench/pfc_host_bench.sv
`timescale 1ns/1ps
`include "pfc_cfg.svh"
// Software sequences over APB against the behavioural flash
module pfc_host_bench;
    localparam logic [7:0] MFR = 8'h3B; // Arbitrary maker code
    localparam logic [7:0] DEV = 8'hC2; // Arbitrary part code
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, hv_req = 0;
    logic ev, pready, pslverr, flash_data_oe, ce_n, oe_n, we_n, hv;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [18:0] flash_addr;
    logic [7:0] flash_data_in, flash_data_out;
    int err_count = 0, n_compared = 0, cyc = 0;
    pfc_host i_dut (.clock, .rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .flash_addr, .flash_data_in,
        .flash_data_out, .flash_data_oe, .chip_enable_n(ce_n),
        .output_enable_n(oe_n), .write_enable_n(we_n),
        .identifier_high_voltage(hv));
    // Sector 2 protected, as programming equipment would leave it
    pfc_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV), .PROT(8'h04)) i_flash (
        .addr(flash_addr), .din(flash_data_out), .ce_n, .oe_n, .we_n,
        .hv, .dout(flash_data_in));
    // Clock and hang limit
    initial forever #5 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask
    // One APB transfer; waits an edge first so no strobe is set twice
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int t;
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1;
        t = 0;
        do begin
            @(posedge clock);
            t++;
        end while (pready !== 1'b1 && t < 20);
        err_count += (t == 20);
        rv = prdata;
        ev = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wait_idle();
        int t;
        t = 0;
        do begin
            apb(0, `PFC_OFF_STATUS, 32'h0);
            t++;
        end while (rv[0] !== 1'b0 && t < 200);
        err_count += (t == 200);
    endtask
    task automatic op(logic [3:0] c, logic [18:0] a, logic [7:0] d);
        apb(1, `PFC_OFF_ADDR, {13'h0, a});
        apb(1, `PFC_OFF_WDATA, {24'h0, d});
        apb(1, `PFC_OFF_CTRL, {26'h0, hv_req, c, 1'b1});
        wait_idle();
    endtask
    task automatic fread(logic [18:0] a);
        op(4'h0, a, 8'h00);
        apb(0, `PFC_OFF_RDATA, 32'h0);
    endtask
    // Polls the byte until it shows the expected value, bounded
    task automatic poll(logic [18:0] a, logic [7:0] e);
        int t;
        t = 0;
        do begin
            fread(a);
            t++;
        end while (rv[7:0] !== e && t < 80);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst <= 0;
        apb(0, `PFC_OFF_PINS, 32'h0);
        check("pins", rv, 32'h300);
        apb(0, 12'h018, 32'h0);
        check("unmapped", {ev, rv[30:0]}, 32'h80000000);
        fread(19'h00100);
        check("blank", rv, 32'hFF);
        $display("test reset done");
        op(4'h4, 19'h11234, 8'h5A);
        apb(1, `PFC_OFF_CTRL, 32'h1);
        apb(1, `PFC_OFF_ADDR, 32'h0);
        check("refused", ev, 1'b1);
        wait_idle();
        apb(0, `PFC_OFF_RDATA, 32'h0);
        check("busy", rv[7], 1'b1);
        poll(19'h11234, 8'h5A);
        check("program", rv, 32'h5A);
        fread(19'h05555);
        check("no latch", rv, 32'hFF);
        op(4'h4, 19'h20010, 8'h00);
        poll(19'h20010, 8'hFF);
        check("protected", rv, 32'hFF);
        op(4'h9, 19'h05555, 8'hAA);
        op(4'h9, 19'h02AAA, 8'h99);
        op(4'h9, 19'h05555, 8'hA0);
        op(4'h9, 19'h11234, 8'h00);
        fread(19'h11234);
        check("bad order", rv, 32'h5A);
        $display("test program done");
        for (int i = 1; i < 3; i++) begin
            op(4'h3, 19'h0, 8'h0);
            fread(19'h00000);
            check("mfr id", rv, {24'h0, MFR});
            fread(19'h40001);
            check("dev id", rv, {24'h0, DEV});
            fread(19'h20002);
            check("prot", rv, 32'h1);
            fread(19'h30002);
            check("unprot", rv, 32'h0);
            op(i[3:0], 19'h0, 8'h0);
            fread(19'h11234);
            check("reset", rv, 32'h5A);
        end
        hv_req = 1;
        fread(19'h7A801);
        check("hv id", rv, {24'h0, DEV});
        hv_req = 0;
        $display("test ident done");
        op(4'h6, 19'h11000, 8'h0);
        op(4'h7, 19'h0, 8'h0);
        fread(19'h11234);
        check("suspended", rv, 32'hFF);
        op(4'h8, 19'h0, 8'h0);
        fread(19'h11234);
        check("resumed", rv[7], 1'b0);
        poll(19'h11234, 8'hFF);
        check("sector erase", rv, 32'hFF);
        op(4'h4, 19'h30005, 8'h33);
        poll(19'h30005, 8'h33);
        op(4'h5, 19'h0, 8'h0);
        poll(19'h30005, 8'hFF);
        check("chip erase", rv, 32'hFF);
        $display("test erase done");
        give_verdict();
    end
endmodule
